// ### hdl/svw_pkg.sv
// Package of constants for the supervisor watchdog reset block
package svw_pkg;
    // Clock rate and period
    localparam int unsigned CLOCK_HZ = 50_000_000;
    localparam int unsigned CLOCK_NS = 20;
    // Nominal watchdog timeout in milliseconds
    localparam int unsigned WDOG_TIMEOUT_MS = 1600;
    // Timeout as clock cycles, rounded down as a longest time
    localparam longint unsigned WDOG_CYCLES_L = longint'(WDOG_TIMEOUT_MS) * CLOCK_HZ / 1000;
    localparam int unsigned WDOG_CYCLES = int'(WDOG_CYCLES_L);
    // Width of the watchdog counter
    localparam int unsigned WDOG_W = 32;
    // Manual reset filter time in microseconds and cycles
    localparam int unsigned MR_FILTER_US = 10;
    localparam int unsigned MR_FILTER_CYCLES = MR_FILTER_US * (CLOCK_HZ / 1_000_000);
    // Width of the filter counter
    localparam int unsigned MR_W = 16;
    // Reset values
    localparam logic RESET_ASSERTED = 1'b1;
    localparam logic KICK_IDLE = 1'b1;
    localparam logic BUTTON_IDLE = 1'b1;
    // Watchdog states
    typedef enum logic [1:0] {
        SVW_DISARMED,
        SVW_RUNNING,
        SVW_EXPIRED
    } svw_state_t;
endpackage : svw_pkg

// ### hdl/svw_button_filter.sv
// Glitch filter for the manual reset button input
`timescale 1ns/1ps
`default_nettype none
module svw_button_filter
    import svw_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = MR_FILTER_CYCLES
) (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic resetn,
    input wire logic clockEnable,
    // Raw and filtered button level
    input wire logic buttonRawN,
    output logic buttonPressed
);
    typedef struct packed {
        logic sample;
        logic [MR_W-1:0] count;
        logic pressed;
    } svw_filt_t;

    svw_filt_t st;
    svw_filt_t next_st;

    // A new level is accepted only once it has stayed put for the full filter time
    always_comb begin
        next_st = st;
        next_st.sample = buttonRawN;
        if (buttonRawN != st.sample) begin
            next_st.count = '0; // RULE_05
        end else if (st.count < MR_W'(FILTER_CYCLES - 1)) begin
            next_st.count = st.count + MR_W'(1);
        end else begin
            next_st.pressed = ~st.sample; // RULE_05
        end
    end

    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st.sample <= BUTTON_IDLE;
            st.count <= '0;
            st.pressed <= 1'b0;
        end else if (clockEnable) begin
            st <= next_st;
        end
    end

    assign buttonPressed = st.pressed;

    // A one-cycle low pulse never reaches the output
    a_filter_glitch: assert property (@(posedge clock) disable iff (!resetn) // RULE_05
        (clockEnable && !st.pressed && st.count == '0 && !buttonRawN)[*1] ##1
        (clockEnable && buttonRawN) |=> ##1 !st.pressed)
        else $error("short button glitch was accepted");
endmodule : svw_button_filter
`default_nettype wire

// ### hdl/svw_supervisor.sv
// Reset supervisor with manual reset and watchdog
//
// Behaviour
// RULE_01 - Reset output high while any reset cause holds, low otherwise.
// RULE_02 - Supply below trip level asserts the reset output.
// RULE_03 - Manual reset input held low asserts the reset output.
// RULE_04 - Manual reset input high leaves reset to the other causes.
// RULE_05 - Short noise pulses on manual reset are filtered out.
// RULE_06 - No kick edge within the timeout asserts the reset output.
// RULE_07 - Any kick edge, rising or falling, clears the watchdog counter.
// RULE_08 - Watchdog counts only after a falling kick edge; host supplies it.
// RULE_09 - Timeout is a build-time parameter, fixed at run time.
// RULE_10 - Default timeout is nominally 1.6 s.
// RULE_11 - Host must kick faster than the minimum timeout.
// RULE_12 - Supply-below-trip arrives as a synchronised digital input.
`timescale 1ns/1ps
`default_nettype none
module svw_supervisor
    import svw_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = WDOG_CYCLES, // RULE_09 RULE_10
    parameter int unsigned FILTER_CYCLES = MR_FILTER_CYCLES
) (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic resetn,
    input wire logic clockEnable,
    // Supply comparator, high while supply is under supply_trip_level
    input wire logic supplyBelowTrip,
    // Manual reset button, active low
    input wire logic manual_reset_n,
    // Watchdog kick from the host
    input wire logic watchdog_kick_in,
    // Reset toward the host, active high
    output logic hostReset,
    // Watchdog status
    output logic watchdogArmed,
    output logic watchdogExpired
);
    // All state except the button filter's in one register, filled by one process
    typedef struct packed {
        svw_state_t state;
        logic kickLast;
        logic [WDOG_W-1:0] watchdog_timer;
        logic resetOut;
    } svw_main_t;

    svw_main_t st;
    svw_main_t next_st;
    logic buttonPressed;
    logic kickEdge;
    logic kickFall;

    // Button filter
    svw_button_filter #(
        .FILTER_CYCLES(FILTER_CYCLES)
    ) u_filter (
        .clock(clock),
        .resetn(resetn),
        .clockEnable(clockEnable),
        .buttonRawN(manual_reset_n),
        .buttonPressed(buttonPressed)
    );

    // Kick edge detection
    // History resets to the idle level so leaving reset shows no false edge
    assign kickEdge = watchdog_kick_in != st.kickLast; // RULE_07
    assign kickFall = st.kickLast && !watchdog_kick_in; // RULE_08

    // Watchdog sequencing and reset combination
    always_comb begin
        next_st = st;
        next_st.kickLast = watchdog_kick_in;
        unique case (st.state)
            SVW_DISARMED: begin
                // Counter held at zero until the host arms it
                next_st.watchdog_timer = '0;
                if (kickFall) begin
                    next_st.state = SVW_RUNNING; // RULE_08
                end
            end
            SVW_RUNNING: begin
                if (kickEdge) begin
                    next_st.watchdog_timer = '0; // RULE_07
                end else if (st.watchdog_timer >= WDOG_W'(TIMEOUT_CYCLES - 1)) begin
                    next_st.state = SVW_EXPIRED; // RULE_06
                    // Cleared so a later kick resumes from zero
                    next_st.watchdog_timer = '0;
                end else begin
                    next_st.watchdog_timer = st.watchdog_timer + WDOG_W'(1);
                end
            end
            SVW_EXPIRED: begin
                // Held until the host kicks again
                if (kickEdge) begin
                    next_st.state = SVW_RUNNING; // RULE_07
                end
            end
            default: next_st.state = SVW_DISARMED;
        endcase
        // Any cause asserts reset, none releases it
        next_st.resetOut = supplyBelowTrip // RULE_01 RULE_02 RULE_12
            || buttonPressed // RULE_03 RULE_04
            || (next_st.state == SVW_EXPIRED); // RULE_06
    end

    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st.state <= SVW_DISARMED;
            st.kickLast <= KICK_IDLE;
            st.watchdog_timer <= '0;
            // Host held in reset while this block is, as at power-up
            st.resetOut <= RESET_ASSERTED;
        end else if (clockEnable) begin
            st <= next_st;
        end
    end

    // Outputs
    assign hostReset = st.resetOut;
    assign watchdogArmed = st.state != SVW_DISARMED;
    assign watchdogExpired = st.state == SVW_EXPIRED;

    // Supply low asserts reset on the next edge
    a_supply_reset: assert property (@(posedge clock) disable iff (!resetn) // RULE_02
        (clockEnable && supplyBelowTrip) |=> hostReset)
        else $error("supply low without reset");

    // Filtered button press asserts reset
    a_button_reset: assert property (@(posedge clock) disable iff (!resetn) // RULE_03
        (clockEnable && buttonPressed) |=> hostReset)
        else $error("button press without reset");

    // No cause means reset released
    a_reset_release: assert property (@(posedge clock) disable iff (!resetn) // RULE_01
        (clockEnable && !supplyBelowTrip && !buttonPressed && st.state == SVW_DISARMED)
        |=> !hostReset)
        else $error("reset held without cause");

    // Button released leaves reset to watchdog and supply
    a_button_free: assert property (@(posedge clock) disable iff (!resetn) // RULE_04
        (clockEnable && !buttonPressed && !supplyBelowTrip && st.state == SVW_RUNNING
        && kickEdge) |=> !hostReset)
        else $error("released button still resets");

    // Disarmed watchdog never arms without a falling edge
    a_arm_fall: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
        (st.state == SVW_DISARMED && !(clockEnable && kickFall)) |=> st.state == SVW_DISARMED)
        else $error("watchdog armed without falling edge");

    // Falling edge arms the watchdog
    a_arm_start: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
        (st.state == SVW_DISARMED && clockEnable && kickFall) |=> watchdogArmed)
        else $error("falling edge did not arm");

    // Kick edge clears the counter
    a_kick_clear: assert property (@(posedge clock) disable iff (!resetn) // RULE_07
        (st.state == SVW_RUNNING && clockEnable && kickEdge)
        |=> (st.watchdog_timer == '0 && !watchdogExpired))
        else $error("kick did not clear counter");

    // Counter at limit with no kick expires and resets
    a_timeout_fire: assert property (@(posedge clock) disable iff (!resetn) // RULE_06
        (st.state == SVW_RUNNING && clockEnable && !kickEdge
        && st.watchdog_timer == WDOG_W'(TIMEOUT_CYCLES - 1))
        |=> (watchdogExpired && hostReset))
        else $error("timeout did not reset");

    // Counter below limit does not expire
    a_timeout_early: assert property (@(posedge clock) disable iff (!resetn) // RULE_06
        (st.state == SVW_RUNNING && st.watchdog_timer < WDOG_W'(TIMEOUT_CYCLES - 1))
        |=> !watchdogExpired)
        else $error("watchdog expired early");

    // Each quiet enabled edge adds one to the counter
    a_counter_step: assert property (@(posedge clock) disable iff (!resetn) // RULE_06
        (st.state == SVW_RUNNING && clockEnable && !kickEdge
        && st.watchdog_timer < WDOG_W'(TIMEOUT_CYCLES - 1))
        |=> st.watchdog_timer == $past(st.watchdog_timer) + WDOG_W'(1))
        else $error("counter did not step");

    // Armed and within time with no other cause keeps reset low
    a_running_quiet: assert property (@(posedge clock) disable iff (!resetn) // RULE_01
        (clockEnable && !supplyBelowTrip && !buttonPressed && st.state == SVW_RUNNING
        && st.watchdog_timer < WDOG_W'(TIMEOUT_CYCLES - 1)) |=> !hostReset)
        else $error("reset while watchdog in time");

    // Expired watchdog keeps reset until a kick edge
    a_expired_hold: assert property (@(posedge clock) disable iff (!resetn) // RULE_06
        (st.state == SVW_EXPIRED && !(clockEnable && kickEdge))
        |=> (watchdogExpired && hostReset))
        else $error("expired reset dropped without kick");

    // Kick after expiry resumes counting from zero
    a_expired_resume: assert property (@(posedge clock) disable iff (!resetn) // RULE_07
        (st.state == SVW_EXPIRED && clockEnable && kickEdge)
        |=> (st.state == SVW_RUNNING && st.watchdog_timer == '0))
        else $error("kick after expiry did not resume");

    // Once armed the watchdog stays armed until reset
    a_armed_stays: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
        watchdogArmed |=> watchdogArmed)
        else $error("watchdog disarmed without reset");

    // Disarmed watchdog holds its counter at zero
    a_disarmed_idle: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
        st.state == SVW_DISARMED |-> (st.watchdog_timer == '0 && !watchdogExpired))
        else $error("disarmed watchdog counting");

    // Raw low not yet filtered does not reset
    a_button_pending: assert property (@(posedge clock) disable iff (!resetn) // RULE_05
        (clockEnable && !manual_reset_n && !buttonPressed && !supplyBelowTrip
        && st.state == SVW_DISARMED) |=> !hostReset)
        else $error("unfiltered button caused reset");

    // Enable low holds every register
    a_freeze_state: assert property (@(posedge clock) disable iff (!resetn)
        !clockEnable |=> $stable(st))
        else $error("state moved while enable low");
endmodule : svw_supervisor
`default_nettype wire

// ### tb/svw_host_model.sv
// Host and button model driving the supervisor inputs
`timescale 1ns/1ps
`default_nettype none
module svw_host_model (
    // Clock
    input wire logic clock,
    // Kick and button toward the supervisor
    output var logic kick,
    output var logic buttonN
);
    bit kickOn = 0;
    int kickGap = 30;
    int cnt = 0;
    initial begin
        kick = 1'b1;
        buttonN = 1'b1;
    end
    // Free-running kick, one toggle every kickGap cycles
    always @(posedge clock) begin
        cnt <= (kickOn && cnt < kickGap - 1) ? cnt + 1 : 0;
        if (kickOn && cnt == kickGap - 1) begin
            kick <= #2 ~kick;
        end
    end
    // Single kick edge
    task automatic toggle();
        @(posedge clock);
        #2 kick = ~kick;
    endtask : toggle
    // Button held down for n cycles, pull-up on release
    task automatic press(input int n);
        @(posedge clock);
        #2 buttonN = 1'b0;
        repeat (n) @(posedge clock);
        #2 buttonN = 1'b1;
    endtask : press
endmodule : svw_host_model
`default_nettype wire

// ### tb/test_supervisor_watchdog_reset.sv
// Testbench for the supervisor watchdog reset block
`timescale 1ns/1ps
`default_nettype none
module test_supervisor_watchdog_reset;
    localparam int unsigned TMO = 50;
    localparam int unsigned FLT = 4;
    // Default timeout in ns, from the package figures
    localparam longint unsigned DEF_NS = svw_pkg::WDOG_CYCLES * svw_pkg::CLOCK_NS;
    logic clock;
    logic resetn;
    logic clockEnable;
    logic supplyBelowTrip;
    logic kick;
    logic buttonN;
    logic hostReset;
    logic watchdogArmed;
    logic watchdogExpired;
    int err_count = 0;
    int n_checks = 0;
    int highs;
    svw_host_model host (.clock(clock), .kick(kick), .buttonN(buttonN));
    svw_supervisor #(.TIMEOUT_CYCLES(TMO), .FILTER_CYCLES(FLT)) dut (
        .clock(clock), .resetn(resetn), .clockEnable(clockEnable),
        .supplyBelowTrip(supplyBelowTrip), .manual_reset_n(buttonN),
        .watchdog_kick_in(kick), .hostReset(hostReset),
        .watchdogArmed(watchdogArmed), .watchdogExpired(watchdogExpired));
    // Clock at 50 MHz
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic check(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %b", $time, msg, got);
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : cycles
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic t_supply();
        supplyBelowTrip = 1'b1;
        cycles(2);
        check(hostReset, 1'b1, "supply low");
        supplyBelowTrip = 1'b0;
        cycles(2);
        check(hostReset, 1'b0, "supply good");
        $display("test supply done");
    endtask : t_supply
    task automatic t_unarmed();
        cycles(TMO + 10);
        check(watchdogArmed, 1'b0, "armed without fall");
        check(hostReset, 1'b0, "unarmed reset");
        $display("test unarmed done");
    endtask : t_unarmed
    task automatic t_button();
        host.press(FLT - 2);
        cycles(FLT + 6);
        check(hostReset, 1'b0, "short pulse");
        fork
            host.press(FLT + 10);
        join_none
        cycles(FLT + 4);
        check(hostReset, 1'b1, "button held");
        cycles(FLT + 16);
        check(hostReset, 1'b0, "button released");
        $display("test button done");
    endtask : t_button
    task automatic t_kick();
        host.kickGap = 30;
        host.kickOn = 1;
        cycles(35);
        check(watchdogArmed, 1'b1, "armed after fall");
        highs = 0;
        repeat (200) begin
            cycles(1);
            if (hostReset !== 1'b0) highs++;
        end
        check(highs == 0, 1'b1, "reset while kicked");
        $display("test kick done");
    endtask : t_kick
    task automatic t_timeout();
        host.kickOn = 0;
        host.toggle();
        cycles(TMO - 5);
        check(hostReset, 1'b0, "early timeout");
        cycles(10);
        check(hostReset, 1'b1, "timeout reset");
        check(watchdogExpired, 1'b1, "expired");
        host.toggle();
        cycles(3);
        check(watchdogExpired, 1'b0, "kick clears");
        check(hostReset, 1'b0, "kick releases");
        $display("test timeout done");
    endtask : t_timeout
    task automatic t_enable();
        clockEnable = 1'b0;
        cycles(TMO + 10);
        check(watchdogExpired, 1'b0, "frozen watchdog expired");
        check(hostReset, 1'b0, "frozen reset");
        clockEnable = 1'b1;
        cycles(TMO - 10);
        check(watchdogExpired, 1'b0, "resumed count early");
        cycles(10);
        check(watchdogExpired, 1'b1, "resumed count expired");
        check(hostReset, 1'b1, "resumed count reset");
        $display("test enable done");
    endtask : t_enable
    task automatic t_reset();
        host.toggle();
        resetn = 1'b0;
        cycles(2);
        check(hostReset, 1'b1, "held in reset");
        check(watchdogArmed, 1'b0, "reset disarms");
        resetn = 1'b1;
        cycles(2);
        check(hostReset, 1'b0, "second release");
        check(watchdogArmed, 1'b0, "armed after release");
        host.toggle();
        cycles(2);
        check(watchdogArmed, 1'b1, "rearmed by fall");
        $display("test reset done");
    endtask : t_reset
    // Reset, then the scenarios in order
    initial begin
        resetn = 1'b0;
        clockEnable = 1'b1;
        supplyBelowTrip = 1'b0;
        repeat (20) @(posedge clock);
        #2 resetn = 1'b1;
        cycles(2);
        check(hostReset, 1'b0, "after reset");
        check(DEF_NS == 1_600_000_000, 1'b1, "default timeout");
        t_supply();
        t_unarmed();
        t_button();
        t_kick();
        t_timeout();
        t_enable();
        t_reset();
        report_and_stop();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule : test_supervisor_watchdog_reset
`default_nettype wire
